// ### bcg_pkg.sv
// ****************************************
// Bridge command gating package
// ****************************************
package bcg_pkg;

    // ****************************************
    // Configuration offsets and layout
    // ****************************************
    localparam logic [7:0]  CFG_CMD_OFS  = 8'h04;    // Command register
    localparam logic [7:0]  CFG_STS_OFS  = 8'h06;    // Status register
    localparam logic [15:0] STS_RESET    = 16'h0010; // Status reset value
    localparam logic [15:0] REG_ZERO     = 16'h0000;
    localparam int          BIT_IO_DEC   = 0;        // I/O decode enable
    localparam int          BIT_MEM_DEC  = 1;        // Memory decode enable
    localparam int          BIT_UP_MST   = 2;        // Upstream master enable
    localparam int          BIT_SPC_CYC  = 3;        // Special cycle, tied 0
    localparam int          BIT_WR_INV   = 4;        // Write invalidate, tied 0
    localparam int          BIT_CAP_LIST = 4;        // Capability list, tied 1

    // ****************************************
    // Illegal cycle redirection
    // ****************************************
    localparam logic [31:0] ILLEGAL_ADDR = 32'h0000_0000;
    localparam logic [3:0]  BE_NONE      = 4'h0;

    // Upstream request from the secondary link
    typedef struct packed {
        logic        wr;     // Write when set
        logic        io;     // I/O space when set
        logic        msi;    // Message-signalled interrupt
        logic        illegal;// Redirected illegal cycle
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] data;
        logic [7:0]  tag;
    } bcg_req_s;

    // Completion heading down to the secondary link
    typedef struct packed {
        logic        ur;     // Unsupported request status
        logic [31:0] data;
        logic [7:0]  tag;
    } bcg_cpl_s;

    // Address windows
    typedef struct packed {
        logic [31:0] mem_base;
        logic [31:0] mem_limit;
        logic [31:0] pf_base;
        logic [31:0] pf_limit;
        logic [31:0] io_base;
        logic [31:0] io_limit;
    } bcg_win_s;

    // Downstream completion source
    typedef enum logic [1:0] {
        CPL_IDLE = 2'b00,
        CPL_FWD  = 2'b01,
        CPL_UR   = 2'b10
    } bcg_src_e;

endpackage

// ### bcg_window_decode.sv
`timescale 1ns/100ps
// ****************************************
// Window decoder for primary accesses
// ****************************************
module bcg_window_decode
    import bcg_pkg::*;
(
    input  wire logic        dec_io,      // Access is I/O space
    input  wire logic [31:0] dec_addr,    // Access address
    input  wire bcg_win_s    win,         // Window bounds
    input  wire logic        mem_en,      // Memory decode enable
    input  wire logic        io_en,       // I/O decode enable
    output logic             hit          // Access is claimed
);

    // Inclusive range test, shared by every window
    function automatic logic in_win(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    wire logic mem_hit;
    wire logic io_hit;

    // Memory and prefetchable windows
    assign mem_hit = mem_en && !dec_io &&
        (in_win(dec_addr, win.mem_base, win.mem_limit) ||
         in_win(dec_addr, win.pf_base, win.pf_limit));
    // I/O window
    assign io_hit  = io_en && dec_io &&
        in_win(dec_addr, win.io_base, win.io_limit);
    assign hit     = mem_hit || io_hit;

endmodule // bcg_window_decode

// ### bcg_bridge_gate.sv
`timescale 1ns/100ps
// Function
// - Write-invalidate enable bit always reads zero
// - Special-cycle enable bit always reads zero
// - Master disabled: no real primary requests
// - Master disabled: no MSIs generated or passed
// - Master disabled: upstream cycles become illegal
// - Illegal write goes to address zero, no bytes
// - Illegal read to zero, answered Unsupported Request
// - Master enabled: upstream requests may pass
// - Issued reads complete when data arrives
// - Completions downstream ignore master enable
// - Memory decode off: no memory claims
// - Memory decode on: both memory windows
// - I/O decode off: no I/O claims
// - I/O decode on: I/O window decoded
// - Status register at offset 6, resets 0010h
// - Status capability-list bit reads one
module bcg_bridge_gate
    import bcg_pkg::*;
#(
    parameter int CFG_AW = 8                 // Config offset width
)(
    input  wire logic              clk_sys,       // System clock
    input  wire logic              arst_n,        // Async reset, low
    // Configuration port
    input  wire logic              cfg_wr,        // Config write strobe
    input  wire logic              cfg_rd,        // Config read strobe
    input  wire logic [CFG_AW-1:0] cfg_addr,      // Config byte offset
    input  wire logic [15:0]       cfg_wdata,     // Config write data
    output logic [15:0]            cfg_rdata,     // Config read data
    output logic                   cfg_rvalid,    // Read data valid
    // Upstream requests from the secondary link
    input  wire logic              up_valid,      // Request valid
    input  wire bcg_req_s          up_req,        // Request
    output logic                   up_ready,      // Request taken
    // Requests onto the primary bus
    output logic                   pri_valid,     // Request valid
    output bcg_req_s               pri_req,       // Request
    input  wire logic              pri_ready,     // Primary accepts
    // Completions from the primary bus
    input  wire logic              pcpl_valid,    // Completion valid
    input  wire bcg_cpl_s          pcpl,          // Completion
    output logic                   pcpl_ready,    // Completion taken
    // Completions to the secondary link
    output logic                   dcpl_valid,    // Completion valid
    output bcg_cpl_s               dcpl,          // Completion
    input  wire logic              dcpl_ready,    // Secondary accepts
    // Primary-side decode
    input  wire logic              dec_valid,     // Access to decode
    input  wire logic              dec_io,        // Access is I/O
    input  wire logic [31:0]       dec_addr,      // Access address
    input  wire bcg_win_s          win,           // Window bounds
    output logic                   dec_claim      // Access claimed
);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (CFG_AW < 3 || CFG_AW > 8) begin : g_bad_aw
        $error("CFG_AW must lie between 3 and 8");
    end

    // ****************************************
    // Command and status registers
    // ****************************************
    logic [2:0] en_q;                  // Master, memory, I/O enables
    logic [2:0] en_d;
    logic       cfg_rvalid_q;
    logic [15:0] cfg_rdata_q;
    logic [15:0] cfg_rdata_d;

    wire logic        hit_cmd;
    wire logic        hit_sts;
    wire logic [15:0] cmd_view;
    wire logic        mst_en;
    wire logic        mem_en;
    wire logic        io_en;

    // Offset decode
    assign hit_cmd = cfg_addr == CFG_AW'(CFG_CMD_OFS);
    assign hit_sts = cfg_addr == CFG_AW'(CFG_STS_OFS);

    // Only the three enables are writable
    assign en_d = (cfg_wr && hit_cmd) ?
                  {cfg_wdata[BIT_UP_MST], cfg_wdata[BIT_MEM_DEC],
                   cfg_wdata[BIT_IO_DEC]} : en_q;

    // Command view; bits 3 and 4 stay zero
    assign cmd_view = {13'h0000, en_q};
    assign mst_en   = en_q[BIT_UP_MST];
    assign mem_en   = en_q[BIT_MEM_DEC];
    assign io_en    = en_q[BIT_IO_DEC];

    // Read mux; status is fixed, unmapped reads zero
    assign cfg_rdata_d = hit_cmd ? cmd_view :
                         hit_sts ? STS_RESET : REG_ZERO;

    // Enable register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= 3'h0;
        end else begin
            en_q <= en_d;
        end
    end

    // Registered read data
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rvalid_q <= 1'b0;
            cfg_rdata_q  <= REG_ZERO;
        end else begin
            cfg_rvalid_q <= cfg_rd;
            cfg_rdata_q  <= cfg_rd ? cfg_rdata_d : cfg_rdata_q;
        end
    end

    assign cfg_rvalid = cfg_rvalid_q;
    assign cfg_rdata  = cfg_rdata_q;

    // ****************************************
    // Upstream gating
    // ****************************************
    logic     pri_valid_q;
    bcg_req_s pri_req_q;
    logic     ur_pend_q;
    bcg_cpl_s ur_cpl_q;
    bcg_src_e src;                     // Completion source, chosen below

    wire logic     up_take;
    wire logic     up_illegal;
    wire logic     ur_block;
    wire bcg_req_s gated_req;
    wire logic     ur_set;
    wire logic     ur_clr;

    // Every upstream cycle is illegal while master is off
    assign up_illegal = !mst_en;
    // An illegal read waits while a UR completion is pending
    assign ur_block   = up_illegal && !up_req.wr && ur_pend_q;
    assign up_ready   = (!pri_valid_q || pri_ready) && !ur_block;
    assign up_take    = up_valid && up_ready;

    // Redirect illegal cycles to address zero, no byte enables
    assign gated_req = up_illegal ?
        bcg_req_s'{wr: up_req.wr, io: 1'b0, msi: 1'b0, illegal: 1'b1,
          addr: ILLEGAL_ADDR, be: BE_NONE,
          data: up_req.data, tag: up_req.tag} :
        up_req;

    // Primary request stage
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pri_valid_q <= 1'b0;
            pri_req_q   <= '0;
        end else begin
            pri_valid_q <= up_take || (pri_valid_q && !pri_ready);
            pri_req_q   <= up_take ? gated_req : pri_req_q;
        end
    end

    assign pri_valid = pri_valid_q;
    assign pri_req   = pri_req_q;

    // Local UR completion for illegal reads
    assign ur_set = up_take && up_illegal && !up_req.wr;
    assign ur_clr = ur_pend_q && dcpl_ready && (src == CPL_UR);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ur_pend_q <= 1'b0;
            ur_cpl_q  <= '0;
        end else begin
            ur_pend_q <= ur_set || (ur_pend_q && !ur_clr);
            ur_cpl_q  <= ur_set ? bcg_cpl_s'{ur: 1'b1, data: 32'h0000_0000,
                                    tag: up_req.tag} : ur_cpl_q;
        end
    end

    // ****************************************
    // Downstream completions
    // ****************************************
    logic     dcpl_valid_q;
    bcg_cpl_s dcpl_q;

    wire logic out_free;

    assign out_free = !dcpl_valid_q || dcpl_ready;

    // Primary completions first, regardless of master enable
    always_comb begin
        src = CPL_IDLE;
        if (out_free && pcpl_valid) begin
            src = CPL_FWD;
        end else if (out_free && ur_pend_q) begin
            src = CPL_UR;
        end
    end

    assign pcpl_ready = src == CPL_FWD;

    // Completion output stage
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dcpl_valid_q <= 1'b0;
            dcpl_q       <= '0;
        end else begin
            case (src)
                CPL_FWD: begin
                    dcpl_valid_q <= 1'b1;
                    dcpl_q       <= pcpl;
                end
                CPL_UR: begin
                    dcpl_valid_q <= 1'b1;
                    dcpl_q       <= ur_cpl_q;
                end
                default: begin
                    dcpl_valid_q <= dcpl_valid_q && !dcpl_ready;
                end
            endcase
        end
    end

    assign dcpl_valid = dcpl_valid_q;
    assign dcpl       = dcpl_q;

    // ****************************************
    // Primary-side claim
    // ****************************************
    logic      claim_q;
    wire logic win_hit;

    bcg_window_decode u_dec (
        .dec_io   (dec_io),
        .dec_addr (dec_addr),
        .win      (win),
        .mem_en   (mem_en),
        .io_en    (io_en),
        .hit      (win_hit)
    );

    // Claim one cycle after the access
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            claim_q <= 1'b0;
        end else begin
            claim_q <= dec_valid && win_hit;
        end
    end

    assign dec_claim = claim_q;

    // ****************************************
    // Assertions
    // ****************************************
    chk_wrinv_zero: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        cfg_rvalid && $past(hit_cmd) |-> !cfg_rdata[BIT_WR_INV])
        else $error("Write-invalidate bit read as one");

    chk_spcyc_zero: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        cfg_rvalid && $past(hit_cmd) |-> !cfg_rdata[BIT_SPC_CYC])
        else $error("Special-cycle bit read as one");

    chk_no_real_req: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        up_take && !mst_en |=> pri_req.illegal)
        else $error("Real request issued with master off");

    chk_msi_blocked: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        up_take && !mst_en && up_req.msi |=> !pri_req.msi)
        else $error("MSI passed with master off");

    chk_illegal_class: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pri_valid && pri_req.illegal |-> pri_req.addr == ILLEGAL_ADDR)
        else $error("Illegal cycle not redirected");

    chk_wr_redirect: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        up_take && !mst_en && up_req.wr
        |=> pri_valid && pri_req.be == BE_NONE && pri_req.addr == ILLEGAL_ADDR)
        else $error("Illegal write kept byte enables");

    chk_rd_ur: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        ur_set |=> ##[0:40] (dcpl_valid && dcpl.ur))
        else $error("Illegal read got no UR completion");

    chk_pass_req: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        up_take && mst_en |=> pri_valid && pri_req.addr == $past(up_req.addr)
        && !pri_req.illegal)
        else $error("Enabled request not forwarded");

    chk_cpl_fwd: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pcpl_valid && out_free |=> dcpl_valid && dcpl == $past(pcpl))
        else $error("Primary completion not forwarded");

    chk_mem_off: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !mem_en && !dec_io |=> !dec_claim)
        else $error("Memory claimed with decode off");

    chk_io_off: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !io_en && dec_io |=> !dec_claim)
        else $error("I/O claimed with decode off");

    chk_sts_value: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        cfg_rvalid && $past(hit_sts) |-> cfg_rdata == STS_RESET)
        else $error("Status read wrong value");

    chk_cap_bit: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        cfg_rvalid && $past(hit_sts) |-> cfg_rdata[BIT_CAP_LIST])
        else $error("Capability bit read as zero");

    chk_cmd_write: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        cfg_wr && hit_cmd |=> en_q == $past({cfg_wdata[BIT_UP_MST],
        cfg_wdata[BIT_MEM_DEC], cfg_wdata[BIT_IO_DEC]}))
        else $error("Command enables not written");

    chk_cpl_taken: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        pcpl_valid && !dcpl_valid |-> pcpl_ready)
        else $error("Primary completion refused with output free");

    chk_mem_claim: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        dec_valid && mem_en && !dec_io &&
        ((dec_addr >= win.mem_base && dec_addr <= win.mem_limit) ||
         (dec_addr >= win.pf_base && dec_addr <= win.pf_limit)) |=> dec_claim)
        else $error("Memory window access not claimed");

    chk_io_claim: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        dec_valid && io_en && dec_io &&
        dec_addr >= win.io_base && dec_addr <= win.io_limit |=> dec_claim)
        else $error("I/O window access not claimed");

endmodule // bcg_bridge_gate

// ### bcg_gfx_model.sv
`timescale 1ns/100ps
// ****************************************
// Graphics device model on the secondary link
// ****************************************
module bcg_gfx_model
    import bcg_pkg::*;
(
    input  wire logic     clk_sys,    // System clock
    input  wire logic     arst_n,     // Async reset, low
    input  wire logic     slow,       // Stall completions
    output bcg_req_s      up_req,     // Upstream request
    output logic          up_valid,   // Request valid
    input  wire logic     up_ready,   // Request taken
    input  wire logic     dcpl_valid, // Completion valid
    input  wire bcg_cpl_s dcpl,       // Completion
    output logic          dcpl_ready  // Completion accepted
);
    bcg_cpl_s   last_cpl;
    logic [7:0] cpl_cnt;
    logic       rdy_q;

    // Ready every cycle, or every other cycle when slow
    assign dcpl_ready = !slow || rdy_q;

    // Capture each accepted completion
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdy_q    <= 1'b0;
            cpl_cnt  <= 8'h00;
            last_cpl <= '0;
        end else begin
            rdy_q <= !rdy_q;
            if (dcpl_valid && dcpl_ready) begin
                last_cpl <= dcpl;
                cpl_cnt  <= cpl_cnt + 8'h01;
            end
        end
    end

    // Idle lines at time zero
    initial begin
        up_valid = 1'b0;
        up_req   = '0;
    end

    // Send one request and hold it until taken
    task automatic send(input bcg_req_s r, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clk_sys);
        #1;
        up_valid = 1'b1;
        up_req   = r;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge clk_sys);
            ok = up_ready;
        end
        #1;
        up_valid = 1'b0;
        up_req   = ~r;    // Released lines lose the old value
    endtask
endmodule // bcg_gfx_model

// ### tb_bcg_bridge_gate.sv
`timescale 1ns/100ps
module tb_bcg_bridge_gate
    import bcg_pkg::*;
;
    logic        clk_sys, arst_n, cfg_wr, cfg_rd, cfg_rvalid, slow;
    logic        up_valid, up_ready, pri_valid, pri_ready, pcpl_valid, pcpl_ready;
    logic        dcpl_valid, dcpl_ready, dec_valid, dec_io, dec_claim;
    logic [7:0]  cfg_addr;
    logic [15:0] cfg_wdata, cfg_rdata;
    logic [31:0] dec_addr;
    bcg_req_s    up_req, pri_req;
    bcg_cpl_s    pcpl, dcpl;
    bcg_win_s    win;
    int          err_total, cmp_count;
    bit          ok;

    bcg_bridge_gate bcg_bridge_gate_i (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .up_valid(up_valid), .up_req(up_req), .up_ready(up_ready),
        .pri_valid(pri_valid), .pri_req(pri_req), .pri_ready(pri_ready),
        .pcpl_valid(pcpl_valid), .pcpl(pcpl), .pcpl_ready(pcpl_ready),
        .dcpl_valid(dcpl_valid), .dcpl(dcpl), .dcpl_ready(dcpl_ready),
        .dec_valid(dec_valid), .dec_io(dec_io), .dec_addr(dec_addr), .win(win),
        .dec_claim(dec_claim));

    bcg_gfx_model bcg_gfx_model_i (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow),
        .up_req(up_req), .up_valid(up_valid), .up_ready(up_ready),
        .dcpl_valid(dcpl_valid), .dcpl(dcpl), .dcpl_ready(dcpl_ready));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic tmo(input bit good);
        if (!good) begin
            err_total++;
            $display("[ERR] %0t wait ran out", $time);
            close_out();
        end
    endtask

    task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys) #1;
        cfg_wr    = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        @(posedge clk_sys) #1;
        cfg_wr    = 1'b0;
    endtask

    task automatic cfg_read(input logic [7:0] a, input logic [15:0] exp);
        int n;
        @(posedge clk_sys) #1;
        cfg_rd   = 1'b1;
        cfg_addr = a;
        @(posedge clk_sys) #1;
        cfg_rd   = 1'b0;
        for (n = 0; n < 20 && cfg_rvalid !== 1'b1; n++) @(posedge clk_sys) #1;
        tmo(cfg_rvalid === 1'b1);
        chk(80'(cfg_rdata), 80'(exp), "config read");
    endtask

    // Take one primary request; illegal ones are compared without payload
    task automatic pri_take(input bcg_req_s e, input bit bare);
        bcg_req_s g;
        int       n;
        for (n = 0; n < 20 && pri_valid !== 1'b1; n++) @(posedge clk_sys) #1;
        tmo(pri_valid === 1'b1);
        g = pri_req;
        if (bare) begin
            g.data = e.data;
            g.tag  = e.tag;
        end
        chk(80'(g), 80'(e), "primary request");
        pri_ready = 1'b1;
        @(posedge clk_sys) #1;
        pri_ready = 1'b0;
    endtask

    task automatic wait_cpl(input logic [7:0] prev, input bcg_cpl_s e);
        int n;
        for (n = 0; n < 40 && bcg_gfx_model_i.cpl_cnt == prev; n++) @(posedge clk_sys) #1;
        tmo(bcg_gfx_model_i.cpl_cnt != prev);
        chk(80'(bcg_gfx_model_i.last_cpl), 80'(e), "down completion");
    endtask

    task automatic pcpl_send(input bcg_cpl_s c);
        int n;
        bit got;
        got = 1'b0;
        @(posedge clk_sys) #1;
        pcpl_valid = 1'b1;
        pcpl       = c;
        for (n = 0; n < 20 && !got; n++) begin
            @(posedge clk_sys);
            got = pcpl_ready;
        end
        tmo(got);
        #1;
        pcpl_valid = 1'b0;
        pcpl       = ~c;
    endtask

    task automatic dec_try(input logic io, input logic [31:0] a, input logic exp);
        @(posedge clk_sys) #1;
        dec_valid = 1'b1;
        dec_io    = io;
        dec_addr  = a;
        @(posedge clk_sys) #1;
        dec_valid = 1'b0;
        chk(80'(dec_claim), 80'(exp), "decode claim");
    endtask

    // Clock generator
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        bcg_req_s   r;
        bcg_req_s   x;
        logic [2:0] kind [5];
        logic [7:0] prev;
        kind = '{3'b100, 3'b110, 3'b101, 3'b000, 3'b010};
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, slow, pri_ready} = '0;
        {pcpl_valid, pcpl, dec_valid, dec_io, dec_addr} = '0;
        win = '{32'h1000_0000, 32'h1000_FFFF, 32'h2000_0000, 32'h2FFF_FFFF,
                32'h0000_1000, 32'h0000_1FFF};
        err_total = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        cfg_read(CFG_STS_OFS, STS_RESET);
        cfg_read(CFG_CMD_OFS, REG_ZERO);
        cfg_write(CFG_CMD_OFS, 16'hFFFF);
        cfg_read(CFG_CMD_OFS, 16'h0007);
        cfg_write(CFG_STS_OFS, REG_ZERO);
        cfg_read(CFG_STS_OFS, STS_RESET);
        cfg_write(8'h0A, REG_ZERO);
        cfg_read(CFG_CMD_OFS, 16'h0007);
        // Master on: write and interrupt pass unchanged
        r = '{1'b1, 1'b0, 1'b0, 1'b0, 32'h1000_0040, 4'hF, 32'hCAFE_0001, 8'h11};
        bcg_gfx_model_i.send(r, ok);
        tmo(ok);
        pri_take(r, 1'b0);
        r.msi = 1'b1;
        bcg_gfx_model_i.send(r, ok);
        tmo(ok);
        pri_take(r, 1'b0);
        // Master off: every kind becomes an illegal cycle
        cfg_write(CFG_CMD_OFS, 16'h0003);
        for (int e = 0; e < 5; e++) begin
            r = '{kind[e][2], kind[e][1], kind[e][0], 1'b0, 32'h1000_0080, 4'hF,
                  32'h5555_0000, 8'(e + 32)};
            x = '{kind[e][2], 1'b0, 1'b0, 1'b1, ILLEGAL_ADDR, BE_NONE, r.data, r.tag};
            prev = bcg_gfx_model_i.cpl_cnt;
            bcg_gfx_model_i.send(r, ok);
            tmo(ok);
            pri_take(x, 1'b1);
            if (!r.wr) wait_cpl(prev, '{1'b1, 32'h0, r.tag});
        end
        // Completions still flow down with master off, far side stalling
        slow = 1'b1;
        prev = bcg_gfx_model_i.cpl_cnt;
        pcpl_send('{1'b0, 32'h1234_5678, 8'h5A});
        wait_cpl(prev, '{1'b0, 32'h1234_5678, 8'h5A});
        slow = 1'b0;
        // Window decode for each enable setting
        for (int en = 0; en < 4; en++) begin
            cfg_write(CFG_CMD_OFS, 16'(en));
            dec_try(1'b0, win.mem_base, en[1]);
            dec_try(1'b0, win.pf_limit, en[1]);
            dec_try(1'b0, 32'h1001_0000, 1'b0);
            dec_try(1'b1, win.io_limit, en[0]);
            dec_try(1'b1, 32'h0000_2000, 1'b0);
        end
        // Reset again in mid-run: enables return to zero
        arst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        cfg_read(CFG_CMD_OFS, REG_ZERO);
        cfg_read(CFG_STS_OFS, STS_RESET);
        close_out();
    end
endmodule // tb_bcg_bridge_gate
